// >>> rtl/pcrc_top.sv
// pcrc_top: programmable crc control, apb registers, input fifo and shifter
//
// How it works
// - bit 13 set stops block in idle
// - bits 12..8 read fifo word count
// - fifo holds 8 long or 16 short words
// - bit 7 reads one when fifo full
// - bit 6 reads one when fifo empty
// - bit 4 starts or stops the shifter
// - bits 3..0 hold length minus one
// - bits 15,14,5 read zero, writes ignored
`timescale 1ns/10ps
module pcrc_top #(
    parameter int unsigned W = 16,                         // widest word and crc
    parameter int unsigned DEPTH = 16                      // fifo storage words
) (
    input wire logic i_clk,                                // system clock, 250 MHz
    input wire logic i_rst_n,                              // sync reset, active low
    input wire logic i_idle_mode,                          // device is in idle mode
    input wire logic i_psel,                               // apb select
    input wire logic i_penable,                            // apb access phase
    input wire logic i_pwrite,                             // apb direction, 1 = write
    input wire logic [pcrc_pkg::PCRC_AW-1:0] i_paddr,      // apb byte address
    input wire logic [31:0] i_pwdata,                      // apb write data
    output logic [31:0] o_prdata,                          // apb read data
    output logic o_pready,                                 // apb ready
    output logic o_pslverr,                                // apb error, unmapped address
    output logic o_irq                                     // level interrupt
);
    import pcrc_pkg::*;

    // ==============================
    // state
    typedef struct packed {
        logic idle_stop;                                   // idle_stop_select
        logic go;                                          // shifter_start
        logic [3:0] poly_length_minus_one;                                  // poly_length_minus_one
        logic [W-1:0] taps;                                // poly_taps_reg
        logic [DEPTH-1:0][W-1:0] mem;                      // fifo storage
        logic [3:0] wptr;                                  // fifo write index
        logic [3:0] rptr;                                  // fifo read index
        logic [4:0] count;                                 // fifo_word_count
        logic [PCRC_NEV-1:0] istat;                        // sticky events
        logic [PCRC_NEV-1:0] ien;                          // event enables
        logic full_d;                                      // full flag last cycle
        logic busy_d;                                      // work pending last cycle
        logic ack;                                         // answer due this cycle
        logic [31:0] rdata;                                // captured read data
        logic slverr;                                      // captured error
    } pcrc_top_s;

    pcrc_top_s st_ff;                                      // registered state
    pcrc_top_s nxt_st;                                     // next state

    // ==============================
    // decode and shared terms
    logic acc;                                             // access phase
    logic wr_now;                                          // write takes effect this edge
    logic mapped;                                          // address hits a register
    logic [4:0] max_words;                                 // fifo limit for this length
    logic [4:0] nbits;                                     // bits per word
    logic full;                                            // fifo full
    logic empty;                                           // fifo empty
    logic run;                                             // shifter may advance
    logic sh_ready;                                        // shifter idle
    logic [W-1:0] crc;                                     // shifter result
    logic push;                                            // accepted data write
    logic drop;                                            // data write while full
    logic pop;                                             // word handed to shifter
    logic seed_we;                                         // software writes the result
    logic [PCRC_NEV-1:0] ev;                               // events this cycle
    logic [15:0] ctrl_rd;                                  // control register view

    // apb decode, one wait state before each answer
    always_comb begin
        acc = i_psel && i_penable;
        wr_now = acc && st_ff.ack && i_pwrite;
        case (i_paddr)
            PCRC_OFS_CTRL, PCRC_OFS_POLY, PCRC_OFS_DATA, PCRC_OFS_RES,
            PCRC_OFS_ISTAT, PCRC_OFS_IEN, PCRC_OFS_ICLR: mapped = 1'b1;
            default: mapped = 1'b0;                        // unmapped answers with error
        endcase
    end

    // fifo limits follow the length field
    always_comb begin
        if (st_ff.poly_length_minus_one > PCRC_POLY_LENGTH_MINUS_ONE_SPLIT) begin
            max_words = PCRC_MAX_LONG;
            nbits = PCRC_BITS_LONG;
        end else begin
            max_words = PCRC_MAX_SHORT;
            nbits = PCRC_BITS_SHORT;
        end
        full = (st_ff.count >= max_words);
        empty = (st_ff.count == 5'h00);
    end

    // flow between bus, fifo and shifter
    always_comb begin
        run = st_ff.go && !(st_ff.idle_stop && i_idle_mode);
        push = wr_now && i_paddr == PCRC_OFS_DATA && !full;
        drop = wr_now && i_paddr == PCRC_OFS_DATA && full;
        pop = run && sh_ready && !empty;
        seed_we = wr_now && i_paddr == PCRC_OFS_RES;
    end

    // control register as software sees it
    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[PCRC_B_IDLE] = st_ff.idle_stop;
        ctrl_rd[PCRC_B_CNT_LO +: 5] = st_ff.count;
        ctrl_rd[PCRC_B_FULL] = full;
        ctrl_rd[PCRC_B_EMPTY] = empty;
        ctrl_rd[PCRC_B_GO] = st_ff.go;
        ctrl_rd[PCRC_B_POLY_LENGTH_MINUS_ONE_LO +: 4] = st_ff.poly_length_minus_one;
    end

    // events: drained, became full, dropped word
    always_comb begin
        ev = '0;
        ev[PCRC_EV_DONE] = st_ff.busy_d && empty && sh_ready && !pop;
        ev[PCRC_EV_FULL] = full && !st_ff.full_d;
        ev[PCRC_EV_OVF] = drop;
    end

    // ==============================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.full_d = full;
        nxt_st.busy_d = !(empty && sh_ready);
        // apb answer sequencing
        if (acc && !st_ff.ack) begin
            nxt_st.ack = 1'b1;                             // answer next cycle
            nxt_st.slverr = !mapped;
            // only reads capture, so read data stands until the next read
            if (!i_pwrite) begin
                case (i_paddr)
                    PCRC_OFS_CTRL: nxt_st.rdata = {16'h0000, ctrl_rd};
                    PCRC_OFS_POLY: nxt_st.rdata = 32'(st_ff.taps);
                    PCRC_OFS_RES: nxt_st.rdata = 32'(crc);
                    PCRC_OFS_ISTAT: nxt_st.rdata = 32'(st_ff.istat);
                    PCRC_OFS_IEN: nxt_st.rdata = 32'(st_ff.ien);
                    default: nxt_st.rdata = 32'h0000_0000; // data, clear and unmapped read zero
                endcase
            end
        end else begin
            nxt_st.ack = 1'b0;                             // answer lasts one cycle
        end
        // register writes, only writable fields stored
        if (wr_now) begin
            case (i_paddr)
                PCRC_OFS_CTRL: begin
                    nxt_st.idle_stop = i_pwdata[PCRC_B_IDLE];
                    nxt_st.go = i_pwdata[PCRC_B_GO];
                    nxt_st.poly_length_minus_one = i_pwdata[PCRC_B_POLY_LENGTH_MINUS_ONE_LO +: 4];
                end
                PCRC_OFS_POLY: nxt_st.taps = i_pwdata[W-1:0];
                PCRC_OFS_IEN: nxt_st.ien = i_pwdata[PCRC_NEV-1:0];
                default: begin
                    // data and result handled by flow terms, clear by sticky status, others read only
                end
            endcase
        end
        // fifo storage and pointers
        if (push) begin
            nxt_st.mem[st_ff.wptr] = i_pwdata[W-1:0];
            nxt_st.wptr = st_ff.wptr + 4'h1;
        end
        if (pop) begin
            nxt_st.rptr = st_ff.rptr + 4'h1;
        end
        nxt_st.count = st_ff.count + 5'(push) - 5'(pop);
        // sticky status, a new event beats a clear
        if (wr_now && i_paddr == PCRC_OFS_ICLR) begin
            nxt_st.istat = st_ff.istat & ~i_pwdata[PCRC_NEV-1:0];
        end
        nxt_st.istat = nxt_st.istat | ev;
    end

    // ==============================
    // register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= '{
                idle_stop: 1'b0,
                go: 1'b0,
                poly_length_minus_one: PCRC_RST_POLY_LENGTH_MINUS_ONE,
                taps: PCRC_RST_POLY,
                mem: '0,
                wptr: 4'h0,
                rptr: 4'h0,
                count: 5'h00,
                istat: '0,
                ien: PCRC_RST_IEN,
                full_d: 1'b0,
                busy_d: 1'b0,
                ack: 1'b0,
                rdata: 32'h0000_0000,
                slverr: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==============================
    // serial engine
    pcrc_shifter #(
        .W(W)
    ) u_shifter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(run),
        .i_load(pop),
        .i_word(st_ff.mem[st_ff.rptr]),
        .i_nbits(nbits),
        .i_poly_length_minus_one(st_ff.poly_length_minus_one),
        .i_taps(st_ff.taps),
        .i_seed_we(seed_we),
        .i_seed(i_pwdata[W-1:0]),
        .o_ready(sh_ready),
        .o_crc(crc)
    );

    // ==============================
    // outputs
    assign o_pready = acc && st_ff.ack;
    assign o_prdata = st_ff.rdata;
    assign o_pslverr = acc && st_ff.ack && st_ff.slverr;
    assign o_irq = |(st_ff.istat & st_ff.ien);
endmodule // pcrc_top

// >>> shared/pcrc_pkg.sv
// pcrc_pkg: shared constants for the programmable crc block
package pcrc_pkg;
    // ==============================
    // bus and register map
    localparam int unsigned PCRC_AW = 8;                    // apb address width
    localparam logic [7:0] PCRC_OFS_CTRL = 8'h00;           // checksum_control_reg
    localparam logic [7:0] PCRC_OFS_POLY = 8'h04;           // poly_taps_reg
    localparam logic [7:0] PCRC_OFS_DATA = 8'h08;           // data_input_reg, write pushes
    localparam logic [7:0] PCRC_OFS_RES = 8'h0C;            // result_word_reg
    localparam logic [7:0] PCRC_OFS_ISTAT = 8'h10;          // sticky event status, read only
    localparam logic [7:0] PCRC_OFS_IEN = 8'h14;            // event enable
    localparam logic [7:0] PCRC_OFS_ICLR = 8'h18;           // write one to clear, write only
    // ==============================
    // control register field positions
    localparam int unsigned PCRC_B_IDLE = 13;               // idle_stop_select
    localparam int unsigned PCRC_B_CNT_LO = 8;              // fifo_word_count 12..8
    localparam int unsigned PCRC_B_FULL = 7;                // fifo_full_flag
    localparam int unsigned PCRC_B_EMPTY = 6;               // fifo_empty_flag
    localparam int unsigned PCRC_B_GO = 4;                  // shifter_start
    localparam int unsigned PCRC_B_POLY_LENGTH_MINUS_ONE_LO = 0;             // poly_length_minus_one 3..0
    // ==============================
    // reset values
    localparam logic [3:0] PCRC_RST_POLY_LENGTH_MINUS_ONE = 4'h0;            // length field after reset
    localparam logic [15:0] PCRC_RST_POLY = 16'h0000;       // taps after reset
    localparam logic [15:0] PCRC_RST_RES = 16'h0000;        // crc after reset
    localparam logic [2:0] PCRC_RST_IEN = 3'h0;             // all events masked
    // ==============================
    // fifo sizing by length
    localparam logic [3:0] PCRC_POLY_LENGTH_MINUS_ONE_SPLIT = 4'h7;          // above this: long words
    localparam logic [4:0] PCRC_MAX_LONG = 5'h08;           // words when length field > 7
    localparam logic [4:0] PCRC_MAX_SHORT = 5'h10;          // words when length field <= 7
    localparam logic [4:0] PCRC_BITS_LONG = 5'h10;          // bits per long word
    localparam logic [4:0] PCRC_BITS_SHORT = 5'h08;         // bits per short word
    // ==============================
    // event bits
    localparam int unsigned PCRC_EV_DONE = 0;               // fifo drained and shifter idle
    localparam int unsigned PCRC_EV_FULL = 1;               // fifo became full
    localparam int unsigned PCRC_EV_OVF = 2;                // push dropped while full
    localparam int unsigned PCRC_NEV = 3;                   // number of events
endpackage

// >>> rtl/pcrc_shifter.sv
// pcrc_shifter: bit-serial crc engine, one data bit per clock
`timescale 1ns/10ps
module pcrc_shifter #(
    parameter int unsigned W = 16                          // widest crc and word
) (
    input wire logic i_clk,                                // system clock
    input wire logic i_rst_n,                              // sync reset, active low
    input wire logic i_run,                                // shifting allowed this cycle
    input wire logic i_load,                               // take i_word, only when o_ready
    input wire logic [W-1:0] i_word,                       // word, short words in low byte
    input wire logic [4:0] i_nbits,                        // bits in this word
    input wire logic [3:0] i_poly_length_minus_one,                         // length minus one
    input wire logic [W-1:0] i_taps,                       // feedback taps
    input wire logic i_seed_we,                            // software writes crc
    input wire logic [W-1:0] i_seed,                       // value for the crc
    output logic o_ready,                                  // no bits left to shift
    output logic [W-1:0] o_crc                             // crc, masked to length
);
    import pcrc_pkg::*;

    // ==============================
    // state
    typedef struct packed {
        logic [W-1:0] crc;                                 // crc register
        logic [W-1:0] sh;                                  // data bits, msb goes first
        logic [4:0] left;                                  // bits still to shift
    } pcrc_sh_s;

    pcrc_sh_s st_ff;                                       // registered state
    pcrc_sh_s nxt_st;                                      // next state
    logic [W-1:0] mask;                                    // crc width mask
    logic fb;                                              // feedback bit

    // next state
    always_comb begin
        nxt_st = st_ff;
        mask = W'((32'h1 << (32'(i_poly_length_minus_one) + 1)) - 1);
        fb = st_ff.crc[i_poly_length_minus_one] ^ st_ff.sh[W-1];
        if (i_seed_we) begin
            nxt_st.crc = i_seed & mask;                    // seed wins over a shift
        end else if (i_run && st_ff.left != 5'h00) begin
            nxt_st.crc = ((st_ff.crc << 1) ^ (fb ? i_taps : '0)) & mask;
            nxt_st.sh = st_ff.sh << 1;
            nxt_st.left = st_ff.left - 5'h01;
        end
        if (i_load && st_ff.left == 5'h00) begin
            // short words are moved to the top so the msb leads
            nxt_st.sh = (i_nbits == PCRC_BITS_SHORT) ? (i_word << (W - 8)) : i_word;
            nxt_st.left = i_nbits;
        end
    end

    // register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= '{crc: PCRC_RST_RES, sh: '0, left: 5'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_ready = (st_ff.left == 5'h00);
    assign o_crc = st_ff.crc;
endmodule // pcrc_shifter

// >>> bench/pcrc_chk.sv
// pcrc_chk: port-level checks of the crc block bus and control word
`timescale 1ns/10ps
module pcrc_chk #(
    parameter int unsigned DEPTH = 16                      // fifo storage words
) (
    input wire logic i_clk,                                // system clock
    input wire logic i_rst_n,                              // sync reset, active low
    input wire logic i_idle_mode,                          // device idle
    input wire logic i_psel,                               // apb select
    input wire logic i_penable,                            // apb access phase
    input wire logic i_pwrite,                             // apb direction
    input wire logic [pcrc_pkg::PCRC_AW-1:0] i_paddr,      // apb address
    input wire logic [31:0] i_pwdata,                      // apb write data
    input wire logic [31:0] o_prdata,                      // apb read data
    input wire logic o_pready,                             // apb ready
    input wire logic o_pslverr,                            // apb error
    input wire logic o_irq                                 // interrupt
);
    // ==============================
    // clocking and bus phases
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_setup; i_psel && !i_penable; endsequence   // first bus cycle
    sequence s_access; i_psel && i_penable; endsequence   // access cycle
    sequence s_ctrl_rd; o_pready && !i_pwrite && i_paddr == pcrc_pkg::PCRC_OFS_CTRL; endsequence
    // ==============================
    // bus timing
    AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !o_pready ##1 o_pready)
        else $error("ready not after one wait state");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
    AST_READY_IN_ACCESS: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
    AST_ERR_UNMAPPED: assert property (o_pready |-> o_pslverr == (i_paddr > 8'h18 || i_paddr[1:0] != 2'h0))
        else $error("error flag does not match address");
    AST_RDATA_HOLD: assert property (!(i_psel && i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data moved without a read");
    // ==============================
    // control word fields
    AST_CTRL_RSVD: assert property (s_ctrl_rd |-> o_prdata[31:14] == '0 && !o_prdata[5])
        else $error("unused control bits not zero");
    AST_EMPTY_COUNT: assert property (s_ctrl_rd |-> o_prdata[6] == (o_prdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    AST_FULL_AT_MAX: assert property (s_ctrl_rd |-> o_prdata[7] ==
        (o_prdata[12:8] >= ((o_prdata[3:0] > 4'h7) ? 5'h08 : 5'h10))) else $error("full flag wrong");
    AST_COUNT_MAX: assert property (s_ctrl_rd |-> o_prdata[12:8] <= DEPTH)
        else $error("count above depth");
endmodule // pcrc_chk

bind pcrc_top pcrc_chk #(.DEPTH(DEPTH)) chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_idle_mode(i_idle_mode),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

// >>> bench/programmable_crc_control_tb.sv
// programmable_crc_control_tb: self-checking bench of the crc control block
`timescale 1ns/10ps
module programmable_crc_control_tb;
    import pcrc_pkg::*;
    // ==============================
    // stimulus and scoreboard state
    logic i_clk, i_rst_n, i_idle_mode, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd, taps, word;
    int fails, checks, c, p, nb;
    typedef struct {logic [32:0] exp; logic [31:0] msk;} pcrc_note_s;
    pcrc_note_s notes[$];
    pcrc_note_s n;
    pcrc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_idle_mode(i_idle_mode), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));
    // ==============================
    // clock and watchdog
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        #200000;
        fails++;
        results();
    end
    // ==============================
    // compare, bus and model tasks
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_irq(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        i_psel <= 1'b0; i_penable <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
        notes.push_back('{{err, e}, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic drain();
        for (int k = 0; k < 400 && rd[6] !== 1'b1; k++) apb(1'b0, PCRC_OFS_CTRL, 32'h0);
        repeat (20) @(posedge i_clk);
    endtask
    function automatic logic [31:0] crc_model(input logic [15:0] t, input logic [15:0] w, input int pl, input int bits);
        logic [15:0] cr;
        logic fb;
        cr = 16'h0000;
        for (int i = bits - 1; i >= 0; i--) begin
            fb = cr[pl] ^ w[i];
            cr = ((cr << 1) ^ (fb ? t : 16'h0000)) & (16'hFFFF >> (15 - pl));
        end
        return {16'h0000, cr};
    endfunction
    task automatic results();
        $display("counts: checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==============================
    // read monitor: oldest note against each read answer
    always @(posedge i_clk) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            cmp({o_pslverr, o_prdata & n.msk}, n.exp);
        end
    end
    // ==============================
    // main sequence
    initial begin
        i_rst_n = 1'b0; i_idle_mode = 1'b0; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
        i_paddr = 8'h00; i_pwdata = 32'h0; fails = 0; checks = 0; rd = 32'h0;
        void'($urandom(32'h9695D299));
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdx(PCRC_OFS_CTRL, 32'h40, 32'hFFFFFFFF, 1'b0);
        cmp_irq(o_irq, 1'b0);
        $display("test reset done");
        apb(1'b1, PCRC_OFS_CTRL, 32'hFFFFFFEF);
        rdx(PCRC_OFS_CTRL, 32'h204F, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, PCRC_OFS_CTRL, 32'h00000017);
        rdx(PCRC_OFS_CTRL, 32'h0057, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, PCRC_OFS_CTRL, 32'h0000200F);
        $display("test fields done");
        apb(1'b1, PCRC_OFS_IEN, 32'h7);
        for (int k = 1; k <= 9; k++) begin
            apb(1'b1, PCRC_OFS_DATA, $urandom);
            c = (k > 8) ? 8 : k;
            rdx(PCRC_OFS_CTRL, 32'h200F | (c << 8) | ((c == 8) ? 32'h80 : 32'h0), 32'hFFFFFFFF, 1'b0);
        end
        rdx(PCRC_OFS_ISTAT, 32'h6, 32'hFFFFFFFF, 1'b0);
        cmp_irq(o_irq, 1'b1);
        apb(1'b1, PCRC_OFS_ICLR, 32'h2);
        rdx(PCRC_OFS_ISTAT, 32'h4, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, PCRC_OFS_IEN, 32'h1);
        // let the enable write land before looking at the level
        @(posedge i_clk);
        cmp_irq(o_irq, 1'b0);
        apb(1'b1, PCRC_OFS_ICLR, 32'h7);
        apb(1'b1, PCRC_OFS_CTRL, 32'h00002007);
        rdx(PCRC_OFS_CTRL, 32'h2807, 32'hFFFFFFFF, 1'b0);
        $display("test fill done");
        @(posedge i_clk);
        i_idle_mode <= 1'b1;
        apb(1'b1, PCRC_OFS_CTRL, 32'h00002017);
        repeat (40) @(posedge i_clk);
        rdx(PCRC_OFS_CTRL, 32'h2817, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, PCRC_OFS_CTRL, 32'h00000017);
        drain();
        rdx(PCRC_OFS_CTRL, 32'h0057, 32'hFFFFFFFF, 1'b0);
        rdx(PCRC_OFS_ISTAT, 32'h1, 32'hFFFFFFFF, 1'b0);
        cmp_irq(o_irq, 1'b1);
        apb(1'b1, PCRC_OFS_ICLR, 32'h7);
        // let the clear land before looking at the level
        @(posedge i_clk);
        cmp_irq(o_irq, 1'b0);
        @(posedge i_clk);
        i_idle_mode <= 1'b0;
        $display("test idle done");
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 15 : (k == 1) ? 7 : $urandom_range(14, 1);
            nb = (p > 7) ? 16 : 8;
            taps = $urandom;
            word = $urandom;
            apb(1'b1, PCRC_OFS_CTRL, p);
            apb(1'b1, PCRC_OFS_RES, 32'h0);
            apb(1'b1, PCRC_OFS_POLY, taps);
            apb(1'b1, PCRC_OFS_DATA, word);
            apb(1'b1, PCRC_OFS_CTRL, 32'h10 | p);
            rd = 32'h0;
            drain();
            rdx(PCRC_OFS_RES, crc_model(taps[15:0], word[15:0], p, nb), 32'hFFFFFFFF, 1'b0);
        end
        $display("test crc done");
        rdx(8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 8'h40, 32'hFFFF);
        // unmapped write must leave the control word alone
        rdx(PCRC_OFS_CTRL, 32'h50 | p, 32'hFFFFFFFF, 1'b0);
        $display("test unmapped done");
        results();
    end
endmodule // programmable_crc_control_tb
